//--- vm_addr_decode.sv
`include "vm_defines.svh"
`default_nettype none
module vm_addr_decode (
	input  wire logic [15:0]   addr,
	output vm_pkg::vm_decode_t dec
);
	// ----------------------------------------
	// region compare
	// ----------------------------------------
	wire logic in_regs  = addr <= `VM_REG_LAST;
	wire logic in_ram   = addr <= `VM_RAM_LAST;
	wire logic in_stack = addr >= `VM_STACK_BASE && addr <= `VM_STACK_LAST;
	wire logic in_prog  = addr >= `VM_PROG_BASE;
	wire logic in_vec   = addr >= `VM_VEC_BASE;
	wire logic in_vrsvd = in_vec && addr <= `VM_VEC_RSVD_LAST;

	assign dec.vector_area = in_vec;
	assign dec.reserved    = !(in_ram || in_prog) || in_vrsvd;
	assign dec.region      = in_regs  ? vm_pkg::VM_REGION_REGS  :
				 in_stack ? vm_pkg::VM_REGION_STACK :
				 in_ram   ? vm_pkg::VM_REGION_RAM   :
				 in_vrsvd ? vm_pkg::VM_REGION_RSVD  :
				 in_vec   ? vm_pkg::VM_REGION_VEC   :
				 in_prog  ? vm_pkg::VM_REGION_PROG  :
					    vm_pkg::VM_REGION_RSVD;
endmodule : vm_addr_decode
`default_nettype wire

//--- vm_cpu_model.sv
`default_nettype none
module vm_cpu_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [1:0]  ack_lat,
	input  wire logic        vector_valid,
	input  wire logic [15:0] vector_addr,
	output logic             cpu_ack,
	output logic      [15:0] last_vec,
	output logic      [7:0]  n_fetch
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_q;
	// -----------------------------
	// fetch vector, ack after ack_lat
	// -----------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_ack <= 1'b0;
			wait_q <= 2'h0;
			last_vec <= 16'h0000;
			n_fetch <= 8'h00;
		end else if (cpu_ack) begin
			cpu_ack <= 1'b0;
			wait_q <= 2'h0;
		end else if (vector_valid && wait_q == ack_lat) begin
			cpu_ack <= 1'b1;
			last_vec <= vector_addr;
			n_fetch <= n_fetch + 8'h01;
		end else if (vector_valid) begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule : vm_cpu_model
`default_nettype wire

//--- vm_defines.svh
`ifndef VM_DEFINES_SVH
`define VM_DEFINES_SVH

// ----------------------------------------
// address layout
// ----------------------------------------
`define VM_ADDR_SPACE_BYTES  32768
`define VM_RAM_BYTES         1024
`define VM_RAM_BASE          16'h0000
`define VM_RAM_LAST          16'h03FF
`define VM_REG_LAST          16'h003F
`define VM_STACK_BASE        16'h0100
`define VM_STACK_LAST        16'h017F
`define VM_PROG_BASE         16'h8000
`define VM_PROG_LAST         16'hFFFF
`define VM_VEC_BASE          16'hFFE0
`define VM_VEC_RSVD_LAST     16'hFFED

// ----------------------------------------
// vector slots
// ----------------------------------------
`define VM_VEC_USB           16'hFFEE
`define VM_VEC_SERIAL        16'hFFF0
`define VM_VEC_I2C           16'hFFF2
`define VM_VEC_TIMER         16'hFFF4
`define VM_VEC_EXT           16'hFFF6
`define VM_VEC_USB_RESUME    16'hFFF8
`define VM_VEC_FLASH         16'hFFFA
`define VM_VEC_TRAP          16'hFFFC
`define VM_VEC_RESET         16'hFFFE

// ----------------------------------------
// source numbering and masks
// ----------------------------------------
`define VM_NSRC              9
`define VM_SRC_USB           0
`define VM_SRC_SERIAL        1
`define VM_SRC_I2C           2
`define VM_SRC_TIMER         3
`define VM_SRC_EXT           4
`define VM_SRC_USB_RESUME    5
`define VM_SRC_FLASH         6
`define VM_SRC_TRAP          7
`define VM_SRC_RESET         8
`define VM_MASKABLE          9'h07F
`define VM_HALT_WAKE         9'h170

// ----------------------------------------
// apb registers (byte addresses)
// ----------------------------------------
`define VM_OFF_EXT_FLAGS     12'h008
`define VM_OFF_STATUS        12'h040
`define VM_OFF_IRQ_MASK      12'h044
`define VM_OFF_CTRL          12'h048
`define VM_OFF_VECTOR        12'h04C
`define VM_OFF_DECODE_ADDR   12'h050
`define VM_OFF_DECODE_RES    12'h054
`define VM_RST_EXT_FLAGS     8'h00
`define VM_RST_MASK          9'h000
`define VM_CTRL_IMASK_BIT    0
`define VM_CTRL_HALT_BIT     1
`define VM_CTRL_RESET        2'h1
`define VM_ST_VEC_DONE_BIT   0
`define VM_ST_WAKE_BIT       1
`define VM_ST_BAD_BIT        2

`endif

//--- vm_interrupt_map.sv
// Register access over APB was decided locally.
`include "vm_defines.svh"
`default_nettype none
module vm_interrupt_map (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  external_interrupt_inputs,
	input  wire logic        usb_irq,
	input  wire logic        async_serial_interface_irq,
	input  wire logic        i2c_irq,
	input  wire logic        timer_irq,
	input  wire logic        usb_resume_irq,
	input  wire logic        flash_prog_irq,
	input  wire logic        trap_req,
	input  wire logic        soft_reset_req,
	input  wire logic        cpu_ack,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_valid,
	output logic             vector_valid,
	output logic      [15:0] vector_addr,
	output logic      [3:0]  vector_source,
	output logic             halt_exit,
	output logic             cpu_access_reserved,
	output logic      [2:0]  cpu_region,
	output logic             irq
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [7:0] ext_s1_q;
	logic [7:0] ext_s2_q;
	logic [7:0] ext_s3_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 8'h00;
			ext_s2_q <= 8'h00;
			ext_s3_q <= 8'h00;
		end else begin
			ext_s1_q <= external_interrupt_inputs;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	wire logic [7:0] ext_rise = ext_s2_q & ~ext_s3_q;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire logic wr_en   = psel && penable && pwrite;
	wire logic hit_ext = paddr == `VM_OFF_EXT_FLAGS;
	wire logic hit_st  = paddr == `VM_OFF_STATUS;
	wire logic hit_msk = paddr == `VM_OFF_IRQ_MASK;
	wire logic hit_ctl = paddr == `VM_OFF_CTRL;
	wire logic hit_vec = paddr == `VM_OFF_VECTOR;
	wire logic hit_da  = paddr == `VM_OFF_DECODE_ADDR;
	wire logic hit_dr  = paddr == `VM_OFF_DECODE_RES;
	wire logic mapped  = hit_ext | hit_st | hit_msk | hit_ctl | hit_vec | hit_da | hit_dr;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]          ext_flags_q;
	logic [1:0]          ctrl_q;
	logic [2:0]          status_q;
	logic [2:0]          irq_mask_q;
	logic [15:0]         probe_addr_q;
	logic [`VM_NSRC-1:0] pend_q;
	logic [31:0]         prdata_q;

	wire logic imask  = ctrl_q[`VM_CTRL_IMASK_BIT];
	wire logic halted = ctrl_q[`VM_CTRL_HALT_BIT];

	vm_pkg::vm_vector_t vsel;
	vm_pkg::vm_decode_t cpu_dec;
	vm_pkg::vm_decode_t probe_dec;

	vm_vector_sel u_sel (
		.pending (pend_q),
		.imask   (imask),
		.vec     (vsel)
	);

	vm_addr_decode u_cpu_dec (
		.addr (cpu_addr),
		.dec  (cpu_dec)
	);

	vm_addr_decode u_probe_dec (
		.addr (probe_addr_q),
		.dec  (probe_dec)
	);

	// ----------------------------------------
	// external flags: set wins over clear
	// ----------------------------------------
	wire logic       ext_wr  = wr_en && hit_ext;
	wire logic [7:0] ext_d   = (ext_wr ? (ext_flags_q & ~pwdata[7:0]) : ext_flags_q) | ext_rise;
	wire logic       ext_any = |ext_flags_q;

	// ----------------------------------------
	// pending requests
	// ----------------------------------------
	wire logic [`VM_NSRC-1:0] new_req = {soft_reset_req, trap_req, flash_prog_irq,
					     usb_resume_irq, ext_any, timer_irq, i2c_irq,
					     async_serial_interface_irq, usb_irq};
	wire logic [`VM_NSRC-1:0] ack_vec = (cpu_ack && vsel.valid) ?
					    (`VM_NSRC'(1) << vsel.source) : '0;
	// every slot latches until taken; ext slot is set again each cycle any ext flag is set
	wire logic [`VM_NSRC-1:0] pend_d  = (pend_q & ~ack_vec) | new_req;

	// halt wakes only for wake sources, mask bit not considered
	wire logic wake = |(new_req & `VM_HALT_WAKE);

	// ----------------------------------------
	// events into status
	// ----------------------------------------
	wire logic ev_vec = cpu_ack && vsel.valid;
	wire logic ev_wake = halted && wake;
	wire logic ev_bad  = cpu_valid && cpu_dec.reserved;
	wire logic [2:0] ev = {ev_bad, ev_wake, ev_vec};
	wire logic st_wr = wr_en && hit_st;
	wire logic [2:0] status_d = (st_wr ? (status_q & ~pwdata[2:0]) : status_q) | ev;

	wire logic ctl_wr = wr_en && hit_ctl;
	wire logic halted_d = ev_wake ? 1'b0 :
			      ctl_wr  ? pwdata[`VM_CTRL_HALT_BIT] : halted;
	// halted in bit 1, cpu mask in bit 0
	wire logic [1:0] ctrl_d = {halted_d, ctl_wr ? pwdata[`VM_CTRL_IMASK_BIT] : imask};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_flags_q  <= `VM_RST_EXT_FLAGS;
			ctrl_q       <= `VM_CTRL_RESET;
			status_q     <= 3'h0;
			irq_mask_q   <= 3'h0;
			probe_addr_q <= 16'h0000;
			pend_q       <= `VM_RST_MASK;
		end else begin
			ext_flags_q  <= ext_d;
			ctrl_q       <= ctrl_d;
			status_q     <= status_d;
			irq_mask_q   <= (wr_en && hit_msk) ? pwdata[2:0] : irq_mask_q;
			probe_addr_q <= (wr_en && hit_da) ? pwdata[15:0] : probe_addr_q;
			pend_q       <= pend_d;
		end
	end

	// ----------------------------------------
	// apb read path
	// ----------------------------------------
	wire logic [31:0] probe_word = {16'h0000, 8'h00, 2'h0, probe_dec.vector_area,
					probe_dec.reserved, 1'b0, probe_dec.region};
	wire logic [31:0] rd_mux = hit_ext ? {24'h0, ext_flags_q} :
				   hit_st  ? {29'h0, status_q} :
				   hit_msk ? {29'h0, irq_mask_q} :
				   hit_ctl ? {30'h0, ctrl_q} :
				   hit_vec ? {11'h0, vsel.valid, vsel.source, vsel.address} :
				   hit_da  ? {16'h0, probe_addr_q} :
				   hit_dr  ? probe_word : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ----------------------------------------
	// cpu side outputs
	// ----------------------------------------
	assign vector_valid        = vsel.valid;
	assign vector_addr         = vsel.address;
	assign vector_source       = vsel.source;
	assign halt_exit           = ev_wake;
	assign cpu_access_reserved = ev_bad;
	assign cpu_region          = cpu_dec.region;
	assign irq                 = |(status_q & irq_mask_q);
endmodule : vm_interrupt_map
`default_nettype wire

//--- vm_interrupt_map_props.sv
`default_nettype none
module vm_interrupt_map_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pslverr,
	input wire logic        trap_req,
	input wire logic        soft_reset_req,
	input wire logic        cpu_valid,
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_access_reserved,
	input wire logic [2:0]  cpu_region,
	input wire logic        vector_valid,
	input wire logic [15:0] vector_addr,
	input wire logic [3:0]  vector_source
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire        stk = cpu_addr >= 16'h0100 && cpu_addr <= 16'h017F;
	wire [15:0] slot = 16'hFFEE + {11'h000, vector_source, 1'b0};
	vec_slot_a: assert property (vector_valid |-> vector_addr == slot)
		else $error("vector address off its slot");
	trap_take_a: assert property (trap_req |=> vector_valid && vector_source >= 4'h7)
		else $error("trap not vectored");
	rst_take_a: assert property (soft_reset_req |=> vector_source == 4'h8 && vector_valid)
		else $error("reset not vectored");
	regs_low_a: assert property (cpu_valid && cpu_addr <= 16'h003F |-> cpu_region == 3'h1)
		else $error("register region wrong");
	ram_gen_a: assert property (cpu_valid && cpu_addr inside {[16'h0040:16'h03FF]} && !stk
		|-> cpu_region == 3'h0)
		else $error("ram region wrong");
	stack_win_a: assert property (cpu_valid && stk |-> cpu_region == 3'h2)
		else $error("stack region wrong");
	vec_area_a: assert property (cpu_valid && cpu_addr >= 16'hFFEE |-> cpu_region == 3'h4)
		else $error("vector region wrong");
	prog_mem_a: assert property (cpu_valid && cpu_addr inside {[16'h8000:16'hFFDF]}
		|-> cpu_region == 3'h3 && !cpu_access_reserved)
		else $error("program region wrong");
	rsvd_flag_a: assert property (cpu_valid && cpu_addr inside {[16'h0400:16'h7FFF]}
		|-> cpu_access_reserved && cpu_region == 3'h5)
		else $error("reserved access missed");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access");
	ext_c: cover property (vector_valid && vector_source == 4'h4);
	rsv_c: cover property (cpu_access_reserved);
	err_c: cover property (pslverr);
endmodule : vm_interrupt_map_props
`default_nettype wire

//--- vm_interrupt_map_tb_top.sv
`default_nettype none
module vm_interrupt_map_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_valid = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd_v;
	logic [8:0] req = '0;
	logic [7:0] ext = '0, n_fetch;
	logic [15:0] cpu_addr = '0, vector_addr, last_vec;
	logic [3:0] vector_source;
	logic [2:0] cpu_region;
	logic [1:0] ack_lat = '0;
	logic pready, pslverr, cpu_ack, vector_valid, halt_exit, cpu_access_reserved, irq;
	logic er_v, seen;
	int checks = 0, n_mismatch = 0;
	initial forever #2 pclk = ~pclk;
	always @(posedge pclk) if (halt_exit === 1'b1) seen <= 1'b1;
	vm_interrupt_map i_vm_interrupt_map (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .external_interrupt_inputs(ext), .usb_irq(req[0]),
		.async_serial_interface_irq(req[1]), .i2c_irq(req[2]), .timer_irq(req[3]),
		.usb_resume_irq(req[5]), .flash_prog_irq(req[6]), .trap_req(req[7]),
		.soft_reset_req(req[8]), .cpu_ack, .cpu_addr, .cpu_valid, .vector_valid, .vector_addr,
		.vector_source, .halt_exit, .cpu_access_reserved, .cpu_region, .irq);
	vm_cpu_model i_vm_cpu_model (.pclk, .presetn, .ack_lat, .vector_valid, .vector_addr,
		.cpu_ack, .last_vec, .n_fetch);
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	task automatic final_report;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v = prdata;
		er_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic pulse(input int i);
		if (i == 4) ext <= 8'h80;
		else req[i] <= 1'b1;
		@(posedge pclk);
		req <= '0;
		ext <= '0;
		@(posedge pclk);
	endtask : pulse
	task automatic fetch(input logic [15:0] e);
		logic [7:0] n0;
		n0 = n_fetch;
		for (int k = 0; k < 20 && n_fetch == n0; k++) @(posedge pclk);
		cmp("fetched", 32'h1, 32'(n_fetch != n0));
		cmp("vector", 32'(e), 32'(last_vec));
		repeat (3) @(posedge pclk);
	endtask : fetch
	task automatic t_reset_regs;
		apb(12'h008, 0, 0); cmp("ext flags", 32'h0, rd_v);
		apb(12'h044, 0, 0); cmp("mask", 32'h0, rd_v);
		apb(12'h048, 0, 0); cmp("ctrl", 32'h1, rd_v);
		apb(12'h0FC, 1, 32'hFF); cmp("unmapped err", 32'h1, 32'(er_v));
		apb(12'h0FC, 0, 0); cmp("unmapped rd", 32'h0, rd_v);
		cmp("unmapped rd err", 32'h1, 32'(er_v));
		cmp("irq", 32'h0, 32'(irq));
	endtask : t_reset_regs
	task automatic t_trap_mask_halt;
		apb(12'h048, 1, 32'h3);
		seen = 0;
		ack_lat <= 2'h2;
		pulse(7); fetch(16'hFFFC);
		ack_lat <= 2'h0;
		pulse(3); repeat (10) @(posedge pclk);
		cmp("masked", 32'h0, 32'(vector_valid));
		apb(12'h048, 1, 32'h2); fetch(16'hFFF4);
		cmp("no wake", 32'h0, 32'(seen));
		pulse(6); fetch(16'hFFFA);
		cmp("wake", 32'h1, 32'(seen));
		apb(12'h048, 0, 0); cmp("halt ended", 32'h0, rd_v);
	endtask : t_trap_mask_halt
	task automatic t_vectors;
		int src[7] = '{0, 1, 2, 3, 5, 6, 4};
		foreach (src[j]) begin
			pulse(src[j]); fetch(16'hFFEE + 16'(2 * src[j]));
		end
		apb(12'h008, 0, 0); cmp("ext flag", 32'h80, rd_v);
		apb(12'h008, 1, 32'h80);
		apb(12'h008, 0, 0); cmp("ext clear", 32'h0, rd_v);
		repeat (10) @(posedge pclk);
	endtask : t_vectors
	task automatic t_wake_irq;
		apb(12'h048, 1, 32'h2);
		seen = 0;
		pulse(5); fetch(16'hFFF8);
		cmp("usb wake", 32'h1, 32'(seen));
		apb(12'h044, 1, 32'h2); cmp("irq on", 32'h1, 32'(irq));
		apb(12'h040, 1, 32'h2); cmp("irq off", 32'h0, 32'(irq));
		apb(12'h048, 1, 32'h3);
		seen = 0;
		pulse(8); fetch(16'hFFFE);
		cmp("reset wake", 32'h1, 32'(seen));
	endtask : t_wake_irq
	task automatic t_decode;
		logic [15:0] a[10] = '{16'h0, 16'h3F, 16'h40, 16'h100, 16'h17F, 16'h180, 16'h3FF,
			16'h400, 16'h8000, 16'hFFFF};
		logic [2:0] r[10] = '{1, 1, 0, 2, 2, 0, 0, 5, 3, 4};
		foreach (a[j]) begin
			cpu_valid <= 1'b1;
			cpu_addr <= a[j];
			@(posedge pclk);
			cmp("region", 32'(r[j]), 32'(cpu_region));
		end
		cpu_valid <= 1'b0;
		apb(12'h040, 0, 0); cmp("rsvd status", 32'h1, 32'(rd_v[2]));
	endtask : t_decode
	task automatic t_probe;
		apb(12'h050, 1, 32'h0000_0100);
		apb(12'h054, 0, 0); cmp("probe stack", 32'h0000_0002, rd_v);
		apb(12'h050, 1, 32'h0000_FFE4);
		apb(12'h054, 0, 0); cmp("probe vec rsvd", 32'h0000_0035, rd_v);
		apb(12'h050, 0, 0); cmp("probe addr", 32'h0000_FFE4, rd_v);
	endtask : t_probe
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_regs();
		t_trap_mask_halt();
		t_vectors();
		t_wake_irq();
		t_decode();
		t_probe();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		final_report();
	end
endmodule : vm_interrupt_map_tb_top
bind vm_interrupt_map vm_interrupt_map_props i_vm_interrupt_map_props (.pclk, .presetn,
	.psel, .penable, .pslverr, .trap_req, .soft_reset_req, .cpu_valid, .cpu_addr,
	.cpu_access_reserved, .cpu_region, .vector_valid, .vector_addr, .vector_source);
`default_nettype wire

//--- vm_pkg.sv
`default_nettype none
package vm_pkg;
	typedef enum logic [2:0] {
		VM_REGION_RAM   = 3'h0,
		VM_REGION_REGS  = 3'h1,
		VM_REGION_STACK = 3'h2,
		VM_REGION_PROG  = 3'h3,
		VM_REGION_VEC   = 3'h4,
		VM_REGION_RSVD  = 3'h5
	} vm_region_t;

	typedef struct packed {
		vm_region_t region;
		logic       reserved;
		logic       vector_area;
	} vm_decode_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  source;
		logic [15:0] address;
	} vm_vector_t;
endpackage : vm_pkg
`default_nettype wire

//--- vm_vector_sel.sv
`include "vm_defines.svh"
`default_nettype none
module vm_vector_sel (
	input  wire logic [`VM_NSRC-1:0] pending,
	input  wire logic                imask,
	output vm_pkg::vm_vector_t       vec
);
	// ----------------------------------------
	// slot table and priority pick
	// ----------------------------------------
	function automatic logic [15:0] slot(input logic [3:0] s);
		case (s)
			4'h0:    slot = `VM_VEC_USB;
			4'h1:    slot = `VM_VEC_SERIAL;
			4'h2:    slot = `VM_VEC_I2C;
			4'h3:    slot = `VM_VEC_TIMER;
			4'h4:    slot = `VM_VEC_EXT;
			4'h5:    slot = `VM_VEC_USB_RESUME;
			4'h6:    slot = `VM_VEC_FLASH;
			4'h7:    slot = `VM_VEC_TRAP;
			default: slot = `VM_VEC_RESET;
		endcase
	endfunction : slot

	wire logic [`VM_NSRC-1:0] eligible = pending & ~({`VM_NSRC{imask}} & `VM_MASKABLE);
	logic [3:0] pick;

	// highest slot wins, reset above trap above the rest
	always_comb begin
		pick = 4'h0;
		for (int i = 0; i < `VM_NSRC; i++) begin
			if (eligible[i]) begin
				pick = 4'(i);
			end
		end
	end

	assign vec.valid   = |eligible;
	assign vec.source  = pick;
	assign vec.address = slot(pick);
endmodule : vm_vector_sel
`default_nettype wire
